// ===== verilog/dld_defs.svh
// dld_defs.svh: offsets, reset values and timing figures of the
// terminal control-lead block.
// assumes: included by bare name from the design file and the bench.
`ifndef DLD_DEFS_SVH
`define DLD_DEFS_SVH
// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define DLD_OFF_CFG 4'h0
`define DLD_OFF_RATE 4'h4
`define DLD_OFF_STAT 4'h8
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DLD_CFG_RST 16'h0041
`define DLD_RATE_RST 4'h6
// ----------------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------------
`define DLD_CLK_NS 25
`define DLD_SHORT_HI_US 1100
`define DLD_SHORT_MID_US 1500
`define DLD_SHORT_48_US 1900
`define DLD_SHORT_24_US 3800
`define DLD_LONG_ADD_US 15000
`define DLD_SEC_NS 1000000000
`define DLD_DISC_S 5
`define DLD_AS_10_S 6'h0a
`define DLD_AS_30_S 6'h1e
`define DLD_AS_60_S 6'h3c
`endif

// ===== verilog/dld_pkg.sv
// dld_pkg.sv: types shared by the terminal control-lead block.
// assumes: dld_defs.svh is on the include path.
package dld_pkg;
  typedef enum logic [2:0] {
    DLD_CTS_FORCED, DLD_CTS_TRACK_REQ, DLD_CTS_TRACK_CD, DLD_CTS_TRACK_BOTH,
    DLD_CTS_DROP_DISC
  } dld_cts_mode_t;
  typedef enum logic [2:0] {
    DLD_FR_NONE, DLD_FR_AT, DLD_FR_V25_SYNC, DLD_FR_BISYNC, DLD_FR_ASYNC
  } dld_framing_t;
  // configuration word, msb first
  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] cmd_set;
    logic [1:0] anti_stream;
    logic delay_long;
    logic [2:0] cts_mode;
    logic clk_master;
    logic tx_ext;
    logic [1:0] char_len;
    logic async_fmt;
    logic conn_v35;
  } dld_cfg_t;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dld_req_t;
  // lead and framing outputs toward the terminal interface
  typedef struct packed {
    logic cts;
    logic tx_forward;
    logic rx_deliver;
    logic tx_strobe;
    logic ext_master_ref;
    logic conn_v35;
    logic async_fmt;
    logic [3:0] char_bits;
    dld_framing_t framing;
  } dld_lead_t;
endpackage

// ===== verilog/dld_lead_ctrl.sv
// dld_lead_ctrl.sv: terminal-side lead control of a data service unit:
// clear-to-send generation, anti-stream cutoff, transmit clock choice and framing.
// assumes: request_to_send_lead, carrier_detect_lead and external_tx_timing come
// from the terminal pins asynchronously; the other inputs are on clk.
`include "dld_defs.svh"
module dld_lead_ctrl #(
  parameter int unsigned SHORT_HI_CYC = (`DLD_SHORT_HI_US * 1000) / `DLD_CLK_NS,
  parameter int unsigned SHORT_MID_CYC = (`DLD_SHORT_MID_US * 1000) / `DLD_CLK_NS,
  parameter int unsigned SHORT_48_CYC = (`DLD_SHORT_48_US * 1000) / `DLD_CLK_NS,
  parameter int unsigned SHORT_24_CYC = (`DLD_SHORT_24_US * 1000) / `DLD_CLK_NS,
  parameter int unsigned LONG_ADD_CYC = (`DLD_LONG_ADD_US * 1000) / `DLD_CLK_NS,
  parameter int unsigned SEC_CYC = `DLD_SEC_NS / `DLD_CLK_NS,
  parameter int unsigned DISC_CYC = `DLD_DISC_S * (`DLD_SEC_NS / `DLD_CLK_NS)
) (
  input wire logic clk,
  input wire logic rst,
  input wire dld_pkg::dld_req_t req,
  output logic [15:0] rdata,
  input wire logic request_to_send_lead,
  input wire logic carrier_detect_lead,
  input wire logic external_tx_timing,
  input wire logic int_tx_tick,
  input wire logic can_pass,
  input wire logic carrier_loss_event,
  input wire logic switched_digital_mode,
  input wire logic cmd_mode,
  output dld_pkg::dld_lead_t lead
);
  import dld_pkg::*;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  dld_cfg_t cfg;
  logic [3:0] rate;
  wire logic wr_cfg = req.wr && (req.addr == `DLD_OFF_CFG);
  wire logic wr_rate = req.wr && (req.addr == `DLD_OFF_RATE);

  // options land at the next edge, so the lead never sees half a write
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= dld_cfg_t'(`DLD_CFG_RST);
      rate <= `DLD_RATE_RST;
    end else begin
      if (wr_cfg) begin
        cfg <= dld_cfg_t'(req.wdata);
      end
      if (wr_rate) begin
        rate <= req.wdata[3:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] rts_sy;
  logic [1:0] cd_sy;
  logic [2:0] etc_sy;
  always_ff @(posedge clk) begin
    if (rst) begin
      rts_sy <= 2'h0;
      cd_sy <= 2'h0;
      etc_sy <= 3'h0;
    end else begin
      rts_sy <= {rts_sy[0], request_to_send_lead};
      cd_sy <= {cd_sy[0], carrier_detect_lead};
      etc_sy <= {etc_sy[1:0], external_tx_timing};
    end
  end
  wire logic rts_s = rts_sy[1];
  wire logic cd_s = cd_sy[1];
  logic rts_d;
  always_ff @(posedge clk) begin
    if (rst) begin
      rts_d <= 1'b0;
    end else begin
      rts_d <= rts_s;
    end
  end
  wire logic rts_rise = rts_s && !rts_d;
  // etc_sy[0] is only read by etc_sy[1]; edges are found on the later stages
  wire logic ext_rise = etc_sy[1] && !etc_sy[2];

  // --------------------------------------------------------------------------
  // request-to-send delay
  // --------------------------------------------------------------------------
  // rate codes: 0=2.4k 1=4.8k 2=9.6k 3=19.2k 4=38.4k 5=56k 6=64k.
  // nominal figures are used; a secondary channel only widens the allowed
  // maximum, so no extra wait is added for it
  function automatic logic [19:0] dly_target(input logic [3:0] r, input logic lng);
    logic [19:0] base;
    base = 20'(SHORT_HI_CYC);
    case (r)
      4'h0: base = 20'(SHORT_24_CYC);
      4'h1: base = 20'(SHORT_48_CYC);
      4'h2, 4'h3, 4'h4: base = 20'(SHORT_MID_CYC);
      default: base = 20'(SHORT_HI_CYC);
    endcase
    return lng ? 20'(base + 20'(LONG_ADD_CYC)) : base;
  endfunction

  wire logic [19:0] dly_tgt = dly_target(rate, cfg.delay_long);
  logic [19:0] dly_cnt;
  wire logic rts_ok = rts_s && (dly_cnt >= dly_tgt);
  always_ff @(posedge clk) begin
    if (rst || !rts_s) begin
      dly_cnt <= 20'h0;
    end else if (dly_cnt < dly_tgt) begin
      dly_cnt <= dly_cnt + 20'h1;
    end
  end

  // --------------------------------------------------------------------------
  // disconnect hold-off
  // --------------------------------------------------------------------------
  logic [27:0] disc_cnt;
  wire logic disc_hold = (disc_cnt != 28'h0);
  always_ff @(posedge clk) begin
    if (rst) begin
      disc_cnt <= 28'h0;
    end else if (carrier_loss_event && switched_digital_mode) begin
      disc_cnt <= 28'(DISC_CYC);
    end else if (disc_hold) begin
      disc_cnt <= disc_cnt - 28'h1;
    end
  end

  // --------------------------------------------------------------------------
  // anti-stream timer
  // --------------------------------------------------------------------------
  logic [25:0] sub_cnt;
  logic [5:0] as_sec;
  logic stream_block;
  wire logic sec_tick = (sub_cnt == 26'(SEC_CYC - 1));
  wire logic [5:0] as_limit = (cfg.anti_stream == 2'h1) ? `DLD_AS_10_S :
                              (cfg.anti_stream == 2'h2) ? `DLD_AS_30_S :
                              (cfg.anti_stream == 2'h3) ? `DLD_AS_60_S : 6'h0;
  wire logic as_expire = (as_limit != 6'h0) && (as_sec >= as_limit);
  always_ff @(posedge clk) begin
    if (rst || !rts_s || rts_rise) begin
      sub_cnt <= 26'h0;
      as_sec <= 6'h0;
    end else begin
      sub_cnt <= sec_tick ? 26'h0 : sub_cnt + 26'h1;
      if (sec_tick && as_sec != 6'h3f) begin
        as_sec <= as_sec + 6'h1;
      end
    end
  end
  // blocking lasts until the terminal drops its request
  always_ff @(posedge clk) begin
    if (rst || !rts_s) begin
      stream_block <= 1'b0;
    end else if (as_expire) begin
      stream_block <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // clear-to-send selection
  // --------------------------------------------------------------------------
  dld_cts_mode_t mode;
  logic next_cts;
  assign mode = dld_cts_mode_t'(cfg.cts_mode);
  always_comb begin
    case (mode)
      DLD_CTS_FORCED: next_cts = 1'b1;
      DLD_CTS_TRACK_REQ: next_cts = rts_ok && can_pass;
      DLD_CTS_TRACK_CD: next_cts = cd_s && can_pass;
      DLD_CTS_TRACK_BOTH: next_cts = rts_ok && cd_s && can_pass;
      DLD_CTS_DROP_DISC: next_cts = !disc_hold;
      default: next_cts = 1'b1;
    endcase
  end

  // in track-both mode data keeps flowing after carrier loss while the
  // request stays up, even though the lead has dropped
  logic next_fwd;
  always_comb begin
    if (mode == DLD_CTS_TRACK_BOTH) begin
      next_fwd = rts_ok && can_pass && !stream_block;
    end else begin
      next_fwd = next_cts && !stream_block;
    end
  end

  // --------------------------------------------------------------------------
  // transmit clock and framing
  // --------------------------------------------------------------------------
  wire logic next_strobe = cfg.tx_ext ? ext_rise : int_tx_tick;
  wire logic next_ext_ref = cfg.tx_ext && cfg.clk_master;
  wire logic [3:0] char_bits = (cfg.char_len == 2'h0) ? 4'h9 :
                               (cfg.char_len == 2'h1) ? 4'ha : 4'hb;
  dld_framing_t next_framing;
  always_comb begin
    next_framing = DLD_FR_NONE;
    if (cmd_mode) begin
      case (cfg.cmd_set)
        2'h0: next_framing = DLD_FR_AT;
        2'h1: next_framing = DLD_FR_V25_SYNC;
        2'h2: next_framing = cfg.async_fmt ? DLD_FR_ASYNC : DLD_FR_BISYNC;
        default: next_framing = DLD_FR_NONE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      lead <= '0;
    end else begin
      lead.cts <= next_cts;
      lead.tx_forward <= next_fwd;
      lead.rx_deliver <= 1'b1;
      lead.tx_strobe <= next_strobe;
      lead.ext_master_ref <= next_ext_ref;
      lead.conn_v35 <= cfg.conn_v35;
      lead.async_fmt <= cfg.async_fmt;
      lead.char_bits <= cfg.async_fmt ? char_bits : 4'h0;
      lead.framing <= next_framing;
    end
  end

  // --------------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------------
  wire logic [15:0] stat_word = {disc_hold, stream_block, rts_ok, cd_s, rts_s,
                                 lead.cts, as_sec, 4'h0};
  wire logic [15:0] next_rdata = (req.addr == `DLD_OFF_CFG) ? 16'(cfg) :
                                 (req.addr == `DLD_OFF_RATE) ? {12'h0, rate} :
                                 (req.addr == `DLD_OFF_STAT) ? stat_word : 16'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0;
    end else begin
      rdata <= req.rd ? next_rdata : 16'h0;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_forced;
    (mode == DLD_CTS_FORCED) |=> lead.cts;
  endproperty
  a_forced: assert property (p_forced) else $error("forced lead not on");

  sequence s_req_rise;
    (mode == DLD_CTS_TRACK_REQ) && rts_rise && !cfg.delay_long;
  endsequence
  property p_req_delay;
    s_req_rise ##0 (mode == DLD_CTS_TRACK_REQ)[*8] |=> !lead.cts;
  endproperty
  a_req_delay: assert property (p_req_delay) else $error("lead rose too early");

  property p_req_drop;
    (mode == DLD_CTS_TRACK_REQ) && !rts_s |=> !lead.cts;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("lead kept after drop");

  property p_cd_drop;
    (mode == DLD_CTS_TRACK_CD) && !cd_s |=> !lead.cts;
  endproperty
  a_cd_drop: assert property (p_cd_drop) else $error("lead kept on carrier off");

  property p_both;
    (mode == DLD_CTS_TRACK_BOTH) && !cd_s && rts_ok && can_pass && !stream_block
      |=> !lead.cts && lead.tx_forward;
  endproperty
  a_both: assert property (p_both) else $error("track-both data stopped");

  property p_disc;
    (mode == DLD_CTS_DROP_DISC) && carrier_loss_event && switched_digital_mode
      ##1 (mode == DLD_CTS_DROP_DISC)[*8] |-> !lead.cts;
  endproperty
  a_disc: assert property (p_disc) else $error("lead on after disconnect");

  property p_timer_clear;
    rts_rise |=> (as_sec == 6'h0) && (sub_cnt == 26'h0);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

  property p_block_release;
    stream_block && !rts_s |=> !stream_block ##1 lead.rx_deliver;
  endproperty
  a_block_release: assert property (p_block_release) else $error("block held");

  property p_block_fwd;
    stream_block |=> !lead.tx_forward && lead.rx_deliver;
  endproperty
  a_block_fwd: assert property (p_block_fwd) else $error("data passed while blocked");

  property p_timer_off;
    (cfg.anti_stream == 2'h0) |=> !stream_block || $past(stream_block);
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("block while timer off");

  property p_ext_clk;
    cfg.tx_ext && ext_rise |=> lead.tx_strobe;
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("external edge missed");

  property p_master_ref;
    cfg.tx_ext && !cfg.clk_master |=> !lead.ext_master_ref;
  endproperty
  a_master_ref: assert property (p_master_ref) else $error("master ref w/o master");

  property p_framing;
    cmd_mode && (cfg.cmd_set == 2'h2) && cfg.async_fmt |=> lead.framing == DLD_FR_ASYNC;
  endproperty
  a_framing: assert property (p_framing) else $error("wrong command framing");

  property p_sync_len;
    !cfg.async_fmt |=> (lead.char_bits == 4'h0);
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("length set in sync format");

  property p_len_nine;
    cfg.async_fmt && (cfg.char_len == 2'h0) |=> (lead.char_bits == 4'h9);
  endproperty
  a_len_nine: assert property (p_len_nine) else $error("wrong character length");

  property p_at_fmt;
    cmd_mode && (cfg.cmd_set == 2'h0) |=> (lead.framing == DLD_FR_AT);
  endproperty
  a_at_fmt: assert property (p_at_fmt) else $error("command framing follows format");

  property p_req_on;
    (mode == DLD_CTS_TRACK_REQ) && rts_ok && can_pass |=> lead.cts;
  endproperty
  a_req_on: assert property (p_req_on) else $error("lead not on after delay");

  sequence s_long_rise;
    (mode == DLD_CTS_TRACK_REQ) && rts_rise && cfg.delay_long;
  endsequence
  property p_req_long;
    s_long_rise ##0 (mode == DLD_CTS_TRACK_REQ)[*8] |=> !lead.cts;
  endproperty
  a_req_long: assert property (p_req_long) else $error("long delay cut short");

  property p_as_block;
    as_expire && rts_s |=> stream_block;
  endproperty
  a_as_block: assert property (p_as_block) else $error("timeout did not block");

  property p_int_clk;
    !cfg.tx_ext && int_tx_tick |=> lead.tx_strobe;
  endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal tick missed");
endmodule

// ===== testbench/dld_term_model.sv
// dld_term_model.sv: behavioural terminal on the far side of the control leads.
// assumes: the bench commands it; its pins move off the system clock edge.
module dld_term_model (
  input wire logic rts_want,
  input wire logic etc_run,
  output logic request_to_send_lead,
  output logic external_tx_timing
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------------
  // request lead
  // ----------------------------------------------------------------------------
  // the pin lags the command so that it never moves on a sampling edge
  initial request_to_send_lead = 1'b0;
  always @(rts_want) request_to_send_lead <= #7 rts_want;
  // ----------------------------------------------------------------------------
  // terminal timing, 200 ns period, parked low while not transmitting
  // ----------------------------------------------------------------------------
  initial begin
    external_tx_timing = 1'b0;
    forever begin
      #100;
      external_tx_timing = etc_run ? ~external_tx_timing : 1'b0;
    end
  end
endmodule

// ===== testbench/tb_dld_lead_ctrl.sv
// tb_dld_lead_ctrl.sv: self-checking bench of the terminal control-lead block.
// assumes: dld_pkg, dld_lead_ctrl and dld_term_model are compiled before it.
`include "dld_defs.svh"
module tb_dld_lead_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import dld_pkg::*;
  logic clk, rst, rts_want, etc_run, cd, tick, tick_en, can_pass, loss, sw, cmd_mode;
  wire rts_pin, etc_pin;
  dld_req_t req;
  logic [15:0] rdata, d;
  dld_lead_t lead;
  dld_cfg_t c;
  int n_mismatch, cmp_count, nstb, n;
  // short counts keep the run brief; expectations below use the same figures
  localparam int unsigned T_HI = 20;
  localparam int unsigned T_MID = 30;
  localparam int unsigned T_48 = 40;
  localparam int unsigned T_24 = 50;
  localparam int unsigned T_LONG = 100;
  localparam int unsigned T_SEC = 64;
  localparam int unsigned T_DISC = 300;
  dld_lead_ctrl #(.SHORT_HI_CYC(T_HI), .SHORT_MID_CYC(T_MID), .SHORT_48_CYC(T_48),
    .SHORT_24_CYC(T_24), .LONG_ADD_CYC(T_LONG), .SEC_CYC(T_SEC), .DISC_CYC(T_DISC))
    dld_lead_ctrl_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .request_to_send_lead(rts_pin), .carrier_detect_lead(cd), .external_tx_timing(etc_pin),
    .int_tx_tick(tick), .can_pass(can_pass), .carrier_loss_event(loss),
    .switched_digital_mode(sw), .cmd_mode(cmd_mode), .lead(lead));
  dld_term_model dld_term_model_inst (.rts_want(rts_want), .etc_run(etc_run),
    .request_to_send_lead(rts_pin), .external_tx_timing(etc_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) tick <= tick_en & ~tick;
  always @(posedge clk) if (lead.tx_strobe === 1'b1) nstb++;
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    chk({15'h0, s}, {15'h0, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse_loss;
    @(posedge clk);
    loss <= 1'b1;
    @(posedge clk);
    loss <= 1'b0;
  endtask
  function automatic dld_cfg_t mk(input logic [2:0] m, input logic lg, input logic [1:0] as);
    dld_cfg_t x;
    x = '0;
    x.conn_v35 = 1'b1;
    x.cts_mode = m;
    x.delay_long = lg;
    x.anti_stream = as;
    return x;
  endfunction
  function automatic int dly(input int r);
    return (r == 0) ? T_24 : (r == 1) ? T_48 : (r < 5) ? T_MID : T_HI;
  endfunction
  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end
  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    {rts_want, etc_run, cd, tick_en, loss, sw, cmd_mode} = 7'h00;
    can_pass = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    nstb = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    rd(`DLD_OFF_CFG, d);
    chk(d, `DLD_CFG_RST);
    rd(`DLD_OFF_RATE, d);
    chk(d, 16'h0006);
    rd(4'hc, d);
    chk(d, 16'h0000);
    wr(4'hc, 16'hffff);
    rd(`DLD_OFF_CFG, d);
    chk(d, `DLD_CFG_RST);
    // command framing and character length over every set and format
    cmd_mode <= 1'b1;
    for (int cs = 0; cs < 4; cs++) begin
      for (int fa = 0; fa < 2; fa++) begin
        c = mk(3'h1, 1'b0, 2'h0);
        c.cmd_set = 2'(cs);
        c.async_fmt = fa[0];
        c.conn_v35 = fa[0];
        c.char_len = 2'(cs);
        wr(`DLD_OFF_CFG, c);
        rd(`DLD_OFF_CFG, d);
        chk(d, c);
        chk1(lead.conn_v35, fa[0]);
        chk1(lead.async_fmt, fa[0]);
        chk({12'h0, lead.char_bits}, fa ? 16'((cs < 2) ? 9 + cs : 11) : 16'h0);
        chk({13'h0, lead.framing}, 16'((cs == 2) ? (fa ? DLD_FR_ASYNC : DLD_FR_BISYNC) :
          (cs == 0) ? DLD_FR_AT : (cs == 1) ? DLD_FR_V25_SYNC : DLD_FR_NONE));
      end
    end
    cmd_mode <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      c = mk(3'h1, 1'b0, 2'h0);
      c.tx_ext = k[0];
      c.clk_master = k[1];
      wr(`DLD_OFF_CFG, c);
      cyc(2);
      chk1(lead.ext_master_ref, k[0] & k[1]);
    end
    // one sampling strobe per internal tick, then per rising terminal timing edge
    tick_en <= 1'b1;
    c.tx_ext = 1'b0;
    wr(`DLD_OFF_CFG, c);
    cyc(4);
    nstb = 0;
    cyc(100);
    chk1(nstb >= 49 && nstb <= 51, 1'b1);
    etc_run <= 1'b1;
    c.tx_ext = 1'b1;
    wr(`DLD_OFF_CFG, c);
    cyc(10);
    nstb = 0;
    cyc(400);
    chk1(nstb >= 49 && nstb <= 51, 1'b1);
    etc_run <= 1'b0;
    tick_en <= 1'b0;
    // forced on, and the unused codes that act as forced
    for (int m = 5; m < 9; m++) begin
      wr(`DLD_OFF_CFG, mk(3'(m), 1'b0, 2'h0));
      cyc(3);
      chk1(lead.cts, 1'b1);
    end
    wr(`DLD_OFF_CFG, mk(3'h1, 1'b0, 2'h0));
    cyc(3);
    chk1(lead.cts, 1'b0);
    // request-to-clear delay at every rate, short and long; code 7 acts as 64k
    for (int r = 0; r < 8; r++) begin
      for (int lg = 0; lg < 2; lg++) begin
        wr(`DLD_OFF_RATE, 16'(r));
        wr(`DLD_OFF_CFG, mk(3'h1, lg[0], 2'h0));
        @(posedge clk);
        rts_want <= 1'b1;
        n = 0;
        do begin
          @(posedge clk);
          #1 n++;
        end while (lead.cts !== 1'b1 && n < 400);
        // two synchroniser stages and the output register follow the count
        chk(16'(n), 16'(dly(r) + (lg ? T_LONG : 0) + 3));
        can_pass <= 1'b0;
        cyc(3);
        chk1(lead.cts, 1'b0);
        can_pass <= 1'b1;
        @(posedge clk);
        rts_want <= 1'b0;
        cyc(6);
        chk1(lead.cts, 1'b0);
      end
    end
    wr(`DLD_OFF_CFG, mk(3'h2, 1'b0, 2'h0));
    cd <= 1'b1;
    cyc(5);
    chk1(lead.cts, 1'b1);
    can_pass <= 1'b0;
    cyc(4);
    chk1(lead.cts, 1'b0);
    can_pass <= 1'b1;
    cd <= 1'b0;
    cyc(5);
    chk1(lead.cts, 1'b0);
    // carrier lost mid-transfer: lead drops, data keeps flowing
    wr(`DLD_OFF_CFG, mk(3'h3, 1'b0, 2'h0));
    cd <= 1'b1;
    rts_want <= 1'b1;
    cyc(40);
    chk1(lead.cts, 1'b1);
    cd <= 1'b0;
    cyc(4);
    chk1(lead.cts, 1'b0);
    chk1(lead.tx_forward, 1'b1);
    rts_want <= 1'b0;
    cyc(12);
    chk1(lead.tx_forward, 1'b0);
    wr(`DLD_OFF_CFG, mk(3'h4, 1'b0, 2'h0));
    sw <= 1'b1;
    cyc(3);
    chk1(lead.cts, 1'b1);
    pulse_loss();
    // hold spans the whole count, lead returns one register later
    cyc(T_DISC);
    chk1(lead.cts, 1'b0);
    cyc(2);
    chk1(lead.cts, 1'b1);
    sw <= 1'b0;
    pulse_loss();
    cyc(5);
    chk1(lead.cts, 1'b1);
    // anti-stream: off, then 10, 30 and 60 seconds
    wr(`DLD_OFF_CFG, mk(3'h1, 1'b0, 2'h0));
    rts_want <= 1'b1;
    cyc(700);
    chk1(lead.tx_forward, 1'b1);
    rts_want <= 1'b0;
    cyc(10);
    for (int a = 1; a < 4; a++) begin
      n = (a == 1) ? 10 : (a == 2) ? 30 : 60;
      wr(`DLD_OFF_CFG, mk(3'h1, 1'b0, 2'(a)));
      rts_want <= 1'b1;
      // block lands five cycles after the last second: look just before and after
      cyc(n * T_SEC);
      chk1(lead.tx_forward, 1'b1);
      cyc(10);
      chk1(lead.tx_forward, 1'b0);
      chk1(lead.rx_deliver, 1'b1);
      rd(`DLD_OFF_STAT, d);
      chk(d, {6'h1b, 6'(n), 4'h0});
      rts_want <= 1'b0;
      cyc(10);
    end
    summarize();
  end
endmodule
